// *** hw/aacr_pkg.sv ***
// Shared constants of the amplifier control register bank and its host.
// Assumes a 100 MHz system clock on both ends of the two-wire bus.
package aacr_pkg;
	// Clock rates and bus bit timing
	localparam int CLK_HZ     = 100_000_000;
	localparam int SCL_HZ     = 400_000;
	localparam int QTR_CYCLES = CLK_HZ / (4 * SCL_HZ);

	// Bus address of the device, arbitrary default
	localparam logic [6:0] DEV_ADDR_DEF = 7'h34;

	// Register addresses
	localparam logic [7:0] ADR_STATUS   = 8'h01;
	localparam logic [7:0] ADR_INT_FLAG = 8'h02;
	localparam logic [7:0] ADR_INT_MASK = 8'h03;
	localparam logic [7:0] ADR_SYS_CTL  = 8'h04;
	localparam logic [7:0] ADR_SYS_CTL2 = 8'h05;
	localparam logic [7:0] ADR_PORT_A   = 8'h06;
	localparam logic [7:0] ADR_PORT_B   = 8'h07;
	localparam logic [7:0] ADR_LVL_THR  = 8'h08;
	localparam logic [7:0] ADR_ATK_TIME = 8'h09;
	localparam logic [7:0] ADR_REL_TIME = 8'h0a;
	localparam logic [7:0] ADR_HLD_TIME = 8'h0b;
	localparam logic [7:0] ADR_BST_VOLT = 8'h20;
	localparam logic [7:0] ADR_BST_THR  = 8'h60;
	localparam logic [7:0] ADR_BOOST_MODE_SEL = 8'h61;

	// Reset values
	localparam logic [15:0] RST_INT_MASK = 16'hffff;
	localparam logic [15:0] RST_SYS_CTL  = 16'hb303;
	localparam logic [15:0] RST_SYS_CTL2 = 16'h6000;
	localparam logic [15:0] RST_PORT_A   = 16'h84e8;
	localparam logic [15:0] RST_PORT_B   = 16'h0010;
	localparam logic [15:0] RST_LVL_THR  = 16'h3940;
	localparam logic [15:0] RST_ATK_TIME = 16'h0030;
	localparam logic [15:0] RST_REL_TIME = 16'h01e0;
	localparam logic [15:0] RST_HLD_TIME = 16'h1c64;
	localparam logic [15:0] RST_BST_THR  = 16'h8402;
	localparam logic [15:0] RST_BOOST_MODE_SEL = 16'h6b3b;

	// Interrupt sources: 4 clock stable, 3 overcurrent, 2 undervolt,
	// 1 overtemp, 0 lock
	localparam int IRQ_BITS = 5;

	// Field positions, system control
	localparam int SC_GAIN_LSB  = 12;
	localparam int SC_LVL_RMS   = 11;
	localparam int SC_LVL_EN    = 10;
	localparam int SC_DC_EN     = 9;
	localparam int SC_MUTE_EN   = 8;
	localparam int SC_PORT_EN   = 6;
	localparam int SC_SWAP      = 5;
	localparam int SC_BCK_INV   = 4;
	localparam int SC_AMP_PD    = 1;
	localparam int SC_SYS_PD    = 0;
	// Field positions and attenuation step scale, second system control
	localparam int S2_PACK      = 15;
	localparam int S2_FILL      = 14;
	localparam int S2_HIZ       = 13;
	localparam int S2_TX_SIDE   = 12;
	localparam int S2_IRQ_PP    = 11;
	localparam int S2_IRQ_LIVE  = 10;
	localparam int VOL_FINE_W   = 6;
	localparam int VOL_STEP_8TH = 48;
	// Field positions, audio port
	localparam int PA_RX_EN     = 15;
	localparam int PA_TX_EN     = 14;

	// Host transfer items
	localparam logic [2:0] IT_START = 3'h0;
	localparam logic [2:0] IT_TX    = 3'h1;
	localparam logic [2:0] IT_RXA   = 3'h2;
	localparam logic [2:0] IT_RXN   = 3'h3;
	localparam logic [2:0] IT_STOP  = 3'h4;
endpackage

// *** hw/aacr_if.sv ***
// Two-wire control bus between host and amplifier register bank.
// Clock line is driven push-pull by the host; data line is open drain.
`timescale 1ns/1ns
interface aacr_if;
	// Clock from host
	logic scl;
	// Data line pull-down enables and resolved level
	logic host_sda_oe;
	logic dev_sda_oe;
	logic sda;

	// Pull-up wins unless someone pulls low
	assign sda = ~(host_sda_oe | dev_sda_oe);

	modport host (output scl, output host_sda_oe, input sda);
	modport dev  (input scl, output dev_sda_oe, input sda);
endinterface

// *** hw/aacr_device.sv ***
// Amplifier control register bank with its two-wire bus slave.
// Assumes the host clocks the bus far below the 100 MHz system clock.
// Contract
// [RQ1] Five interrupt mask bits, each reset one
// [RQ2] Gain field bits 14..12, reset code 3
// [RQ3] Level control peak/RMS select and enable
// [RQ4] DC cancel and mute enables reset on
// [RQ5] Port master, receive, transmit enables
// [RQ6] Channel swap and bit clock invert bits
// [RQ7] System and amplifier power-down reset set
// [RQ8] Attenuation: coarse six dB, fine eighth dB
// [RQ9] Unused slots: fill select, high impedance
// [RQ10] Transmit side select and packing mode
// [RQ11] Interrupt pin drive mode and source
// [RQ12] Input channel left, right or mono
// [RQ13] Port format standard, MSB or LSB
// [RQ14] Data width and bit clock ratio codes
// [RQ15] Sample rate code eight to ninety-six
// [RQ16] Frame sync width slot or bit
// [RQ17] Slot count: two-channel or TDM
// [RQ18] Slot selects, right receive resets one
// [RQ19] Attack and release amplitude thresholds
// [RQ20] Attack, release, hold time counts
// [RQ21] Boost mode and boost thresholds
// [RQ22] Read-only actual boost voltage field
// [RQ23] Eight-bit address, sixteen-bit data, high first
// [RQ24] Software avoids reserved codes
`timescale 1ns/1ns
module aacr_device
#(
	parameter logic [6:0] DEV_ADDR = aacr_pkg::DEV_ADDR_DEF
)
(
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst,
	// Control bus
	aacr_if.dev                                link,
	// Live status and boost readback from the analog side
	input  wire logic [aacr_pkg::IRQ_BITS-1:0] live_status,
	input  wire logic [3:0]                    boost_voltage_actual,
	// Interrupt pin, active low
	output logic                               irq_n_out,
	output logic                               irq_n_oe,
	// Configuration words
	output logic [15:0]                        sys_ctl_r,
	output logic [15:0]                        sys_ctl2_r,
	output logic [15:0]                        port_a_r,
	output logic [15:0]                        port_b_r,
	output logic [15:0]                        lvl_thr_r,
	output logic [15:0]                        atk_time_r,
	output logic [15:0]                        rel_time_r,
	output logic [15:0]                        hld_time_r,
	output logic [15:0]                        bst_thr_r,
	output logic [15:0]                        boost_mode_sel_r,
	// Derived controls
	output logic                               amp_run_r,
	output logic                               rx_active_r,
	output logic                               tx_active_r,
	output logic [9:0]                         atten_eighths_r
);
	import aacr_pkg::*;

	typedef enum logic [6:0] {
		PH_IDLE = 7'b0000001,
		PH_ADDR = 7'b0000010,
		PH_REG  = 7'b0000100,
		PH_WHI  = 7'b0001000,
		PH_WLO  = 7'b0010000,
		PH_RHI  = 7'b0100000,
		PH_RLO  = 7'b1000000
	} aacr_phase_e;

	localparam int SYN_W = IRQ_BITS + 6;

	logic [SYN_W-1:0]    meta_r;
	logic [SYN_W-1:0]    sync_r;
	logic                scl_prev_r;
	logic                sda_prev_r;
	logic                scl;
	logic                sda;
	logic                bus_start;
	logic                bus_stop;
	logic                scl_rise;
	logic                scl_fall;
	logic                reading;
	aacr_phase_e         ph_r;
	logic [3:0]          bit_r;
	logic [7:0]          sr_r;
	logic [15:0]         tx_r;
	logic                ack_r;
	logic                mack_r;
	logic [7:0]          ptr_r;
	logic [7:0]          hi_r;
	logic                wr_stb_r;
	logic [7:0]          wr_addr_r;
	logic [15:0]         wr_data_r;
	logic                rc_stb_r;
	logic                sda_oe_r;
	logic [15:0]         int_mask_r;
	logic [IRQ_BITS-1:0] flag_r;
	logic [IRQ_BITS-1:0] irq_src;
	logic                irq_hit;

	// Read view of the register map, unmapped addresses read zero
	function automatic logic [15:0] rd_word(input logic [7:0] a);
		case (a)
			ADR_STATUS:   rd_word = {11'h000, sync_r[SYN_W-1 -: IRQ_BITS]};
			ADR_INT_FLAG: rd_word = {11'h000, flag_r};
			ADR_INT_MASK: rd_word = int_mask_r;
			ADR_SYS_CTL:  rd_word = sys_ctl_r;
			ADR_SYS_CTL2: rd_word = sys_ctl2_r;
			ADR_PORT_A:   rd_word = port_a_r;
			ADR_PORT_B:   rd_word = port_b_r;
			ADR_LVL_THR:  rd_word = lvl_thr_r;
			ADR_ATK_TIME: rd_word = atk_time_r;
			ADR_REL_TIME: rd_word = rel_time_r;
			ADR_HLD_TIME: rd_word = hld_time_r;
			ADR_BST_VOLT: rd_word = {12'h000, sync_r[5:2]}; // see [RQ22]
			ADR_BST_THR:  rd_word = bst_thr_r;
			ADR_BOOST_MODE_SEL: rd_word = boost_mode_sel_r;
			default:      rd_word = 16'h0000;
		endcase
	endfunction

	// Two-stage synchronisers for pins and analog status
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			meta_r     <= {{(SYN_W-2){1'b0}}, 2'b11}; // No false flags
			sync_r     <= {{(SYN_W-2){1'b0}}, 2'b11};
			scl_prev_r <= 1'b1;
			sda_prev_r <= 1'b1;
		end
		else
		begin
			meta_r     <= {live_status, boost_voltage_actual, link.scl, link.sda};
			sync_r     <= meta_r;
			scl_prev_r <= sync_r[1];
			sda_prev_r <= sync_r[0];
		end
	end

	// Bus conditions seen on the synchronised lines
	assign scl       = sync_r[1];
	assign sda       = sync_r[0];
	assign bus_start = scl & scl_prev_r & sda_prev_r & ~sda;
	assign bus_stop  = scl & scl_prev_r & ~sda_prev_r & sda;
	assign scl_rise  = scl & ~scl_prev_r;
	assign scl_fall  = ~scl & scl_prev_r;
	assign reading   = (ph_r == PH_RHI) || (ph_r == PH_RLO);

	// Bus slave: address, register pointer, sixteen-bit words high byte first
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ph_r      <= PH_IDLE;
			bit_r     <= 4'h0;
			sr_r      <= 8'h00;
			tx_r      <= 16'h0000;
			ack_r     <= 1'b0;
			mack_r    <= 1'b0;
			ptr_r     <= 8'h00;
			hi_r      <= 8'h00;
			wr_stb_r  <= 1'b0;
			wr_addr_r <= 8'h00;
			wr_data_r <= 16'h0000;
			rc_stb_r  <= 1'b0;
		end
		else
		begin
			wr_stb_r <= 1'b0;
			rc_stb_r <= 1'b0;
			if (bus_start)
			begin
				ph_r  <= PH_ADDR;
				bit_r <= 4'hf; // Clock fall after start wraps to zero
				ack_r <= 1'b0;
			end
			else if (bus_stop)
			begin
				ph_r  <= PH_IDLE;
				ack_r <= 1'b0;
			end
			else if (ph_r != PH_IDLE)
			begin
				if (scl_rise && bit_r < 4'h8)
					sr_r <= {sr_r[6:0], sda};
				else if (scl_rise)
					mack_r <= ~sda;
				if (scl_fall && bit_r == 4'h8)
				begin
					bit_r <= 4'h0;
					ack_r <= 1'b0;
					if (!ack_r && reading)
					begin
						if (!mack_r)
							ph_r <= PH_IDLE;
						else if (ph_r == PH_RHI)
							ph_r <= PH_RLO;
						else
						begin
							ptr_r    <= ptr_r + 8'h01; // see [RQ23]
							tx_r     <= rd_word(ptr_r + 8'h01);
							rc_stb_r <= (ptr_r + 8'h01) == ADR_INT_FLAG;
							ph_r     <= PH_RHI;
						end
					end
				end
				else if (scl_fall)
				begin
					bit_r <= bit_r + 4'h1;
					if (reading)
						tx_r <= {tx_r[14:0], 1'b0};
					if (bit_r == 4'h7)
					begin
						case (ph_r)
							PH_ADDR:
							begin
								if (sr_r[7:1] == DEV_ADDR)
								begin
									ack_r <= 1'b1;
									if (sr_r[0])
									begin
										ph_r     <= PH_RHI;
										tx_r     <= rd_word(ptr_r);
										rc_stb_r <= ptr_r == ADR_INT_FLAG;
									end
									else
										ph_r <= PH_REG;
								end
								else
									ph_r <= PH_IDLE;
							end
							PH_REG:
							begin
								ptr_r <= sr_r; // see [RQ23]
								ack_r <= 1'b1;
								ph_r  <= PH_WHI;
							end
							PH_WHI:
							begin
								hi_r  <= sr_r;
								ack_r <= 1'b1;
								ph_r  <= PH_WLO;
							end
							PH_WLO:
							begin
								wr_stb_r  <= 1'b1;
								wr_addr_r <= ptr_r;
								wr_data_r <= {hi_r, sr_r}; // see [RQ23]
								ptr_r     <= ptr_r + 8'h01;
								ack_r     <= 1'b1;
								ph_r      <= PH_WHI;
							end
							default:
								ack_r <= 1'b0;
						endcase
					end
				end
			end
		end
	end

	// Data line pull-down: acknowledge or outgoing zero bits
	always_ff @(posedge clk)
	begin
		if (rst)
			sda_oe_r <= 1'b0;
		else
			sda_oe_r <= (bit_r == 4'h8 && ack_r)
				|| (reading && bit_r < 4'h8 && !tx_r[15]);
	end
	assign link.dev_sda_oe = sda_oe_r;

	// Writable registers; status and readback words ignore writes
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			int_mask_r <= RST_INT_MASK; // see [RQ1]
			sys_ctl_r  <= RST_SYS_CTL; // see [RQ2] [RQ3] [RQ4] [RQ6] [RQ7]
			sys_ctl2_r <= RST_SYS_CTL2; // see [RQ9] [RQ10] [RQ11]
			port_a_r   <= RST_PORT_A; // see [RQ5] [RQ12] [RQ13] [RQ14] [RQ15]
			port_b_r   <= RST_PORT_B; // see [RQ16] [RQ17] [RQ18]
			lvl_thr_r  <= RST_LVL_THR; // see [RQ19]
			atk_time_r <= RST_ATK_TIME; // see [RQ20]
			rel_time_r <= RST_REL_TIME;
			hld_time_r <= RST_HLD_TIME;
			bst_thr_r  <= RST_BST_THR; // see [RQ21]
			boost_mode_sel_r <= RST_BOOST_MODE_SEL;
		end
		else if (wr_stb_r)
		begin
			case (wr_addr_r)
				ADR_INT_MASK: int_mask_r <= wr_data_r;
				ADR_SYS_CTL:  sys_ctl_r  <= wr_data_r;
				ADR_SYS_CTL2: sys_ctl2_r <= wr_data_r;
				ADR_PORT_A:   port_a_r   <= wr_data_r;
				ADR_PORT_B:   port_b_r   <= wr_data_r;
				ADR_LVL_THR:  lvl_thr_r  <= wr_data_r;
				ADR_ATK_TIME: atk_time_r <= wr_data_r;
				ADR_REL_TIME: rel_time_r <= wr_data_r;
				ADR_HLD_TIME: hld_time_r <= wr_data_r;
				ADR_BST_THR:  bst_thr_r  <= wr_data_r;
				ADR_BOOST_MODE_SEL: boost_mode_sel_r <= wr_data_r;
				default:      int_mask_r <= int_mask_r;
			endcase
		end
	end

	// Sticky flags: a live status bit sets, reading the flag word clears
	always_ff @(posedge clk)
	begin
		if (rst)
			flag_r <= '0;
		else
			flag_r <= (rc_stb_r ? '0 : flag_r) | sync_r[SYN_W-1 -: IRQ_BITS];
	end

	// Interrupt pin: latched or live source, masked, open drain or push-pull
	assign irq_src = sys_ctl2_r[S2_IRQ_LIVE] ? sync_r[SYN_W-1 -: IRQ_BITS]
		: flag_r; // see [RQ11]
	assign irq_hit = |(irq_src & ~int_mask_r[IRQ_BITS-1:0]); // see [RQ1]
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			irq_n_out <= 1'b1;
			irq_n_oe  <= 1'b0;
		end
		else if (sys_ctl2_r[S2_IRQ_PP])
		begin
			irq_n_out <= ~irq_hit; // see [RQ11]
			irq_n_oe  <= 1'b1;
		end
		else
		begin
			irq_n_out <= 1'b0;
			irq_n_oe  <= irq_hit;
		end
	end

	// Derived power, port activity and attenuation in eighth-dB steps
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			amp_run_r       <= 1'b0;
			rx_active_r     <= 1'b0;
			tx_active_r     <= 1'b0;
			atten_eighths_r <= 10'h000;
		end
		else
		begin
			amp_run_r   <= ~sys_ctl_r[SC_SYS_PD] & ~sys_ctl_r[SC_AMP_PD]; // see [RQ7]
			rx_active_r <= sys_ctl_r[SC_PORT_EN] & port_a_r[PA_RX_EN]; // see [RQ5]
			tx_active_r <= sys_ctl_r[SC_PORT_EN] & port_a_r[PA_TX_EN];
			atten_eighths_r <= 10'(sys_ctl2_r[9:VOL_FINE_W] * VOL_STEP_8TH)
				+ {4'h0, sys_ctl2_r[VOL_FINE_W-1:0]}; // see [RQ8]
		end
	end
endmodule

// *** hw/aacr_host.sv ***
// Host end: runs one register read or write per command over the bus.
// Assumes the device acknowledges its address; a missing ack ends early.
`timescale 1ns/1ns
module aacr_host
#(
	parameter int QTR = aacr_pkg::QTR_CYCLES
)
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Control bus
	aacr_if.host             link,
	// Command
	input  wire logic        cmd_valid,
	input  wire logic        cmd_write,
	input  wire logic [7:0]  cmd_addr,
	input  wire logic [15:0] cmd_wdata,
	output logic             cmd_ready_r,
	// Response
	output logic             rsp_valid_r,
	output logic [15:0]      rsp_rdata_r,
	output logic             rsp_nack_r
);
	import aacr_pkg::*;

	typedef enum logic [3:0] {
		HS_IDLE  = 4'b0001,
		HS_START = 4'b0010,
		HS_BYTE  = 4'b0100,
		HS_STOP  = 4'b1000
	} aacr_hstate_e;

	aacr_hstate_e st_r;
	logic [15:0]  q_r;
	logic [1:0]   ph_r;
	logic [3:0]   bit_r;
	logic [3:0]   item_r;
	logic         wr_r;
	logic [7:0]   addr_r;
	logic [15:0]  data_r;
	logic [15:0]  rd_r;
	logic         nack_r;
	logic         scl_r;
	logic         sda_oe_r;
	logic [1:0]   sda_s_r;
	logic [10:0]  cur;
	logic [10:0]  nxt;
	logic [7:0]   sh;

	// Transfer items: kind and byte; high data byte goes first
	function automatic logic [10:0] item_of(input logic [3:0] i,
		input logic w);
		case ({w, i})
			5'h10, 5'h00, 5'h03: item_of = {IT_START, 8'h00};
			5'h11, 5'h01:        item_of = {IT_TX, DEV_ADDR_DEF, 1'b0};
			5'h12, 5'h02:        item_of = {IT_TX, addr_r};
			5'h13:               item_of = {IT_TX, data_r[15:8]};
			5'h14:               item_of = {IT_TX, data_r[7:0]};
			5'h04:               item_of = {IT_TX, DEV_ADDR_DEF, 1'b1};
			5'h05:               item_of = {IT_RXA, 8'h00};
			5'h06:               item_of = {IT_RXN, 8'h00};
			default:             item_of = {IT_STOP, 8'h00};
		endcase
	endfunction

	// Which state serves an item kind
	function automatic aacr_hstate_e state_of(input logic [2:0] k);
		case (k)
			IT_START: state_of = HS_START;
			IT_STOP:  state_of = HS_STOP;
			default:  state_of = HS_BYTE;
		endcase
	endfunction

	assign cur = item_of(item_r, wr_r);
	assign nxt = item_of(item_r + 4'h1, wr_r);
	assign sh  = cur[7:0] << bit_r[2:0];

	// Data line synchroniser
	always_ff @(posedge clk)
	begin
		if (rst)
			sda_s_r <= 2'b11;
		else
			sda_s_r <= {sda_s_r[0], link.sda};
	end

	// Bit engine: four quarter phases per bus clock
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_r        <= HS_IDLE;
			q_r         <= 16'h0000;
			ph_r        <= 2'h0;
			bit_r       <= 4'h0;
			item_r      <= 4'h0;
			wr_r        <= 1'b0;
			addr_r      <= 8'h00;
			data_r      <= 16'h0000;
			rd_r        <= 16'h0000;
			nack_r      <= 1'b0;
			scl_r       <= 1'b1;
			sda_oe_r    <= 1'b0;
			cmd_ready_r <= 1'b1;
			rsp_valid_r <= 1'b0;
			rsp_rdata_r <= 16'h0000;
			rsp_nack_r  <= 1'b0;
		end
		else if (st_r == HS_IDLE)
		begin
			rsp_valid_r <= 1'b0;
			scl_r       <= 1'b1;
			sda_oe_r    <= 1'b0;
			if (cmd_valid)
			begin
				wr_r        <= cmd_write;
				addr_r      <= cmd_addr;
				data_r      <= cmd_wdata;
				item_r      <= 4'h0;
				bit_r       <= 4'h0;
				q_r         <= 16'h0000;
				ph_r        <= 2'h0;
				nack_r      <= 1'b0;
				cmd_ready_r <= 1'b0;
				st_r        <= HS_START;
			end
		end
		else if (q_r != 16'(QTR - 1))
			q_r <= q_r + 16'h0001;
		else
		begin
			q_r  <= 16'h0000;
			ph_r <= ph_r + 2'h1;
			case (st_r)
				HS_START:
				begin
					if (ph_r == 2'h0)
						sda_oe_r <= 1'b0;
					if (ph_r == 2'h1)
						scl_r <= 1'b1;
					if (ph_r == 2'h2)
						sda_oe_r <= 1'b1;
					if (ph_r == 2'h3)
					begin
						scl_r  <= 1'b0;
						item_r <= item_r + 4'h1;
						st_r   <= state_of(nxt[10:8]);
					end
				end
				HS_BYTE:
				begin
					if (ph_r == 2'h0 && bit_r < 4'h8)
						sda_oe_r <= (cur[10:8] == IT_TX) && !sh[7];
					else if (ph_r == 2'h0)
						sda_oe_r <= cur[10:8] == IT_RXA;
					if (ph_r == 2'h1)
						scl_r <= 1'b1;
					if (ph_r == 2'h2 && bit_r < 4'h8 && cur[10:8] != IT_TX)
						rd_r <= {rd_r[14:0], sda_s_r[1]};
					if (ph_r == 2'h2 && bit_r == 4'h8 && cur[10:8] == IT_TX)
						nack_r <= sda_s_r[1];
					if (ph_r == 2'h3)
					begin
						scl_r <= 1'b0;
						if (bit_r != 4'h8)
							bit_r <= bit_r + 4'h1;
						else
						begin
							bit_r <= 4'h0;
							if (nack_r)
								st_r <= HS_STOP;
							else
							begin
								item_r <= item_r + 4'h1;
								st_r   <= state_of(nxt[10:8]);
							end
						end
					end
				end
				HS_STOP:
				begin
					if (ph_r == 2'h0)
						sda_oe_r <= 1'b1;
					if (ph_r == 2'h1)
						scl_r <= 1'b1;
					if (ph_r == 2'h2)
						sda_oe_r <= 1'b0;
					if (ph_r == 2'h3)
					begin
						rsp_valid_r <= 1'b1;
						rsp_rdata_r <= rd_r;
						rsp_nack_r  <= nack_r;
						cmd_ready_r <= 1'b1;
						st_r        <= HS_IDLE;
					end
				end
				default:
					st_r <= HS_IDLE;
			endcase
		end
	end

	assign link.scl         = scl_r;
	assign link.host_sda_oe = sda_oe_r;
endmodule

// *** verification/aacr_sva.sv ***
// Wire checks on the two-wire bus joining host and register bank.
// Assumes the bench runs the host with 8 clock cycles per quarter bit.
`timescale 1ns/1ns
module aacr_sva
(
	// Clock and reset
	input	wire logic	clk,
	input	wire logic	rst,
	// Bus lines
	input	wire logic	scl,
	input	wire logic	host_sda_oe,
	input	wire logic	dev_sda_oe,
	input	wire logic	sda
);
	// One clock domain for every check
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	idle_after_reset_a:
		assert property ($fell(rst) |-> scl && !host_sda_oe && !dev_sda_oe)
		else $error("bus not idle after reset");
	scl_high_min_a:
		assert property ($rose(scl) |-> scl[*8])
		else $error("bus clock high too short");
	scl_low_min_a:
		assert property ($fell(scl) |-> !scl[*8])
		else $error("bus clock low too short");
	scl_low_max_a:
		assert property ($fell(scl) |-> ##[1:40] scl)
		else $error("bus clock stuck low");
	dev_edge_low_a:
		assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("device moved data while clock high");
	host_data_hold_a:
		assert property ($rose(scl) |=> $stable(host_sda_oe)[*6])
		else $error("host moved data while clock high");
	start_shape_a:
		assert property ($fell(sda) && scl |-> host_sda_oe ##[1:12] !scl)
		else $error("malformed start");
	dev_release_a:
		assert property ($rose(dev_sda_oe) |-> ##[1:400] !dev_sda_oe)
		else $error("device holds data line too long");

	// Main bus events
	cover property ($fell(sda) && scl);
	cover property ($rose(sda) && scl);
	cover property ($rose(dev_sda_oe));
endmodule

// *** verification/tb_top.sv ***
// Bench joining host and register bank over the two-wire bus.
// Assumes the package constants and a host quarter of 8 cycles.
`timescale 1ns/1ns
module tb_top;
	import aacr_pkg::*;
	logic		clk;
	logic		rst;
	logic		cmd_valid;
	logic		cmd_write;
	logic [7:0]	cmd_addr;
	logic [15:0]	cmd_wdata;
	logic		cmd_ready_r;
	logic		rsp_valid_r;
	logic [15:0]	rsp_rdata_r;
	logic		rsp_nack_r;
	logic [4:0]	live;
	logic [4:0]	lv0;
	logic [3:0]	bva;
	logic		irq_n_out;
	logic		irq_n_oe;
	logic		amp_run_r;
	logic		rx_active_r;
	logic		tx_active_r;
	logic [9:0]	atten_eighths_r;
	logic [17:0]	exp_q[$];
	logic [17:0]	mon_e;
	logic [15:0]	wv[11];
	int		bad_count;
	int		compares;
	int		seed;
	localparam logic [7:0] RA[11] = '{ADR_INT_MASK, ADR_SYS_CTL,
		ADR_SYS_CTL2, ADR_PORT_A, ADR_PORT_B, ADR_LVL_THR, ADR_ATK_TIME,
		ADR_REL_TIME, ADR_HLD_TIME, ADR_BST_THR, ADR_BOOST_MODE_SEL};
	localparam logic [15:0] RV[11] = '{RST_INT_MASK, RST_SYS_CTL,
		RST_SYS_CTL2, RST_PORT_A, RST_PORT_B, RST_LVL_THR, RST_ATK_TIME,
		RST_REL_TIME, RST_HLD_TIME, RST_BST_THR, RST_BOOST_MODE_SEL};
	// Masks that keep random writes clear of reserved codes
	localparam logic [15:0] AM[11] = '{16'hffff, 16'hbfff, 16'hffdf,
		16'hcdd7, 16'hb777, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
		16'hffff, 16'hfff7};
	localparam logic [15:0] OM[11] = '{16'h0000, 16'h1002, 16'h0000,
		16'h0400, 16'h0000, 16'h0000, 16'h0001, 16'h0001, 16'h0001,
		16'h0000, 16'h0000};

	aacr_if aacr_if_inst();

	aacr_device aacr_device_inst
	(
		.clk(clk), .rst(rst), .link(aacr_if_inst),
		.live_status(live), .boost_voltage_actual(bva),
		.irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
		.sys_ctl_r(), .sys_ctl2_r(), .port_a_r(), .port_b_r(),
		.lvl_thr_r(), .atk_time_r(), .rel_time_r(), .hld_time_r(),
		.bst_thr_r(), .boost_mode_sel_r(), .amp_run_r(amp_run_r),
		.rx_active_r(rx_active_r), .tx_active_r(tx_active_r),
		.atten_eighths_r(atten_eighths_r)
	);

	// Short quarters keep each write near 1200 cycles and each read near 1500 cycles
	aacr_host #(.QTR(8)) aacr_host_inst
	(
		.clk(clk), .rst(rst), .link(aacr_if_inst),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.cmd_ready_r(cmd_ready_r), .rsp_valid_r(rsp_valid_r),
		.rsp_rdata_r(rsp_rdata_r), .rsp_nack_r(rsp_nack_r)
	);

	aacr_sva aacr_sva_inst
	(
		.clk(clk), .rst(rst), .scl(aacr_if_inst.scl),
		.host_sda_oe(aacr_if_inst.host_sda_oe),
		.dev_sda_oe(aacr_if_inst.dev_sda_oe), .sda(aacr_if_inst.sda)
	);

	// Free-running system clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Print counts and verdict, then stop
	task automatic tally_and_finish();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Present one command, note its expected response, wait for idle
	task automatic cmd(input logic w, input logic [7:0] a,
		input logic [15:0] d, input logic [17:0] e);
		int n;
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_addr = a;
		cmd_wdata = d;
		exp_q.push_back(e);
		@(negedge clk);
		cmd_valid = 1'b0;
		n = 0;
		while (cmd_ready_r !== 1'b1 && n < 5000)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= 5000)
		begin
			bad_count++;
			tally_and_finish();
		end
	endtask

	// Register write and read with expected word
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		cmd(1'b1, a, d, 18'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] d);
		cmd(1'b0, a, 16'h0, {2'b10, d});
	endtask

	// Direct compare of settled outputs
	task automatic ck(input logic [15:0] got, input logic [15:0] want);
		compares++;
		if (got !== want)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, want);
		end
	endtask

	// Match each response against the oldest noted expectation
	always @(negedge clk)
	begin
		if (rsp_valid_r === 1'b1)
		begin
			compares++;
			mon_e = exp_q.size() > 0 ? exp_q.pop_front() : 18'h3ffff;
			if (rsp_nack_r !== mon_e[16] ||
				(mon_e[17] && rsp_rdata_r !== mon_e[15:0]))
			begin
				bad_count++;
				$display("mismatch at %0t: reply %h", $time, rsp_rdata_r);
			end
		end
	end

	// Main sequence
	initial
	begin
		seed = 32'h9c31;
		bad_count = 0;
		compares = 0;
		rst = 1'b1;
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_addr = 8'h0;
		cmd_wdata = 16'h0;
		live = 5'($random(seed)) | 5'h01;
		lv0 = live;
		bva = 4'($random(seed));
		repeat (10) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		ck({14'h0, amp_run_r, irq_n_oe}, 16'h0);
		// Reset values, then random write and read back
		for (int i = 0; i < 11; i++)
			rd(RA[i], RV[i]);
		rd(ADR_BST_VOLT, {12'h0, bva});
		rd(ADR_STATUS, {11'h0, live});
		for (int i = 0; i < 11; i++)
		begin
			wv[i] = (16'($random(seed)) & AM[i]) | OM[i];
			wr(RA[i], wv[i]);
			rd(RA[i], wv[i]);
		end
		ck({6'h0, atten_eighths_r},
			16'(int'(wv[2][9:6]) * 48 + int'(wv[2][5:0])));
		ck({13'h0, amp_run_r, rx_active_r, tx_active_r},
			{13'h0, !wv[1][1] && !wv[1][0], wv[1][6] && wv[3][15],
			wv[1][6] && wv[3][14]});
		// Configure the port first, power the amplifier up last
		wr(ADR_PORT_A, 16'hc400);
		wr(ADR_SYS_CTL, 16'h3040);
		ck({13'h0, amp_run_r, rx_active_r, tx_active_r}, 16'h7);
		// Read-only and unmapped places
		wr(ADR_BST_VOLT, 16'hffff);
		rd(ADR_BST_VOLT, {12'h0, bva});
		rd(8'h40, 16'h0);
		// Interrupt pin modes and sources
		wr(ADR_SYS_CTL2, 16'h0000);
		wr(ADR_INT_MASK, 16'h0000);
		ck({14'h0, irq_n_oe, irq_n_out}, 16'h2);
		wr(ADR_SYS_CTL2, 16'h0800);
		ck({14'h0, irq_n_oe, irq_n_out}, 16'h2);
		live = 5'h00;
		wr(ADR_SYS_CTL2, 16'h0c00);
		ck({14'h0, irq_n_oe, irq_n_out}, 16'h3);
		rd(ADR_INT_FLAG, {11'h0, lv0});
		rd(ADR_INT_FLAG, 16'h0);
		tally_and_finish();
	end
endmodule
